// ### fps_engine_model.sv
// Purpose: Behavioural command engine answering launches from the block.
// Assumes: One command at a time; nothing is queued.
// Notes:   The bench picks violation and blank results per command.
`timescale 1ns/1ps
module fps_engine_model
#(
  parameter logic [3:0] RUN_CYCLES = 4'h6
)
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic cmd_launch,
  input  wire logic want_viol,
  input  wire logic want_blank,
  output logic      cmd_fetched,
  output logic      cmd_active,
  output logic      prot_violation,
  output logic      verify_done,
  output logic      verify_blank
);
  logic [3:0] run_ff;  // Cycles left of the running command.
  assign cmd_active = (run_ff != 4'h0);
  // Fetch at once, then flag a protected target or run and report.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_ff         <= 4'h0;
      cmd_fetched    <= 1'b0;
      prot_violation <= 1'b0;
      verify_done    <= 1'b0;
      verify_blank   <= 1'b0;
    end else begin
      cmd_fetched    <= cmd_launch;
      prot_violation <= cmd_launch & want_viol;
      verify_done    <= (run_ff == 4'h1);
      // Outside done the result line keeps moving, so nothing relies on a stale value.
      verify_blank   <= (run_ff == 4'h1) ? want_blank : ~verify_blank;
      if (cmd_launch && !want_viol) begin
        run_ff <= RUN_CYCLES;
      end else if (run_ff != 4'h0) begin
        run_ff <= run_ff - 4'h1;
      end
    end
  end
endmodule

// ### fps_flash_status.sv
// Purpose: Status flags, launch gating and protection update of a flash command controller.
// Assumes: Classic Wishbone slave with 32-bit data; command logic shares clk_sys.
// Notes:   Only special_mode comes from a pin and is synchronised before use.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module fps_flash_status
  import fps_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Mode strap from a pin.
  input  wire logic              special_mode,
  // Protection load from the nonvolatile array.
  input  wire logic              prot_load,
  input  wire logic [7:0]        prot_load_value,
  // Command sequence events from the address and command decoders.
  input  wire logic              array_word_wr,
  input  wire logic              cmd_code_wr,
  input  wire logic              cmd_code_illegal,
  input  wire logic              cpu_stop,
  // Execution engine status.
  input  wire logic              cmd_fetched,
  input  wire logic              cmd_active,
  input  wire logic              prot_violation,
  input  wire logic              verify_done,
  input  wire logic              verify_blank,
  // Results.
  output logic                   cmd_launch,
  output logic                   seq_abort,
  output logic      [7:0]        protection_config,
  output logic                   irq_buffer_empty,
  output logic                   irq_complete
);

  // Pin synchroniser for the mode strap; stage one feeds stage two only.
  logic special_meta_ff;
  logic special_ff;

  // Bus handshake and read data.
  logic        ack_ff;
  logic [31:0] rdata_ff;

  // Software visible registers.
  logic [7:0] flash_config_reg_ff;       // Interrupt enables.
  logic [7:0] protection_config_reg_ff;  // Scenario in force.

  // Status flags.
  logic buffer_empty_flag_ff;
  logic command_complete_flag_ff;
  logic protect_violation_flag_ff;
  logic access_error_flag_ff;
  logic erased_flag_ff;
  logic fail_flag_ff;

  // Command write sequence tracker.
  fps_seq_e seq_ff;
  fps_seq_e nxt_seq;

  // Launch and abort pulses.
  logic launch_ff;
  logic abort_ff;

  // Registered interrupt requests.
  logic irq_empty_ff;
  logic irq_done_ff;

  // Decoded bus strobes.
  logic        req;
  logic        wr_fire;
  logic        wr_status;
  logic        wr_prot;
  logic        wr_cfg;
  logic [7:0]  wdat;
  logic [7:0]  status_view;
  logic [7:0]  prot_merged;
  logic        prot_ok;

  // Decoded sequence events.
  logic launch_now;
  logic abort_now;
  logic seq_fault;
  logic blocked;

  // Address match, shared by the read path and every write strobe.
  function automatic logic fps_hit(input logic [ADDR_W-1:0] adr,
                                   input logic [ADDR_W-1:0] target);
    fps_hit = (adr == target);
  endfunction

  // Two flip-flops bring the strap into the clock domain.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      special_meta_ff <= 1'b0;
      special_ff      <= 1'b0;
    end else begin
      special_meta_ff <= special_mode;
      special_ff      <= special_meta_ff;
    end
  end

  // A request is live while cycle and strobe are high.
  assign req     = wb_cyc_i & wb_stb_i;
  // Writes take effect at the edge where the master sees ack.
  assign wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];
  assign wdat    = wb_dat_i[7:0];

  assign wr_status = wr_fire & fps_hit(wb_adr_i, STATUS_ADDR);
  assign wr_prot   = wr_fire & fps_hit(wb_adr_i, PROTECT_CONFIG_ADDR);
  assign wr_cfg    = wr_fire & fps_hit(wb_adr_i, FLASH_CONFIG_ADDR);

  // Ack follows one cycle after the request and drops the cycle after;
  // unmapped addresses are acked too and read as zero.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end
  assign wb_ack_o = ack_ff;

  // Status as software sees it; fail and done hide in normal modes.
  always_comb begin
    status_view                = 8'h00;
    status_view[BIT_BUF_EMPTY] = buffer_empty_flag_ff;
    status_view[BIT_COMPLETE]  = command_complete_flag_ff;
    status_view[BIT_PROT_VIOL] = protect_violation_flag_ff;
    status_view[BIT_ACC_ERR]   = access_error_flag_ff;
    status_view[BIT_ERASED]    = erased_flag_ff;
    if (special_ff) begin
      status_view[BIT_FAIL] = fail_flag_ff;
      status_view[BIT_DONE] = ~cmd_active;
    end
  end

  // Read data is captured on the request cycle so it is stable under ack.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      if (fps_hit(wb_adr_i, STATUS_ADDR)) begin
        rdata_ff[7:0] <= status_view;
      end else if (fps_hit(wb_adr_i, PROTECT_CONFIG_ADDR)) begin
        rdata_ff[7:0] <= protection_config_reg_ff;
      end else if (fps_hit(wb_adr_i, FLASH_CONFIG_ADDR)) begin
        rdata_ff[7:0] <= flash_config_reg_ff;
      end
    end
  end
  assign wb_dat_o = rdata_ff;

  // Interrupt enables; only the two enable bits are stored.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flash_config_reg_ff <= FLASH_CONFIG_RST;
    end else if (wr_cfg) begin
      flash_config_reg_ff                   <= 8'h00;
      flash_config_reg_ff[BIT_BUF_EMPTY_IE] <= wdat[BIT_BUF_EMPTY_IE];
      flash_config_reg_ff[BIT_COMPLETE_IE]  <= wdat[BIT_COMPLETE_IE];
    end
  end

  // Filter that judges a protection write against the current scenario.
  fps_prot_filter u_prot_filter (
    .cur_cfg    (protection_config_reg_ff),
    .wr_cfg     (wdat),
    .merged_cfg (prot_merged),
    .change_ok  (prot_ok)
  );

  // Protection register: array load wins, then filtered software writes.
  // Writes are refused in special modes since the load defines the setting there.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      protection_config_reg_ff <= PROTECT_CONFIG_RST;
    end else if (prot_load) begin
      protection_config_reg_ff <= prot_load_value;
    end else if (wr_prot & ~special_ff & prot_ok) begin
      protection_config_reg_ff <= prot_merged;
    end
  end
  assign protection_config = protection_config_reg_ff;

  // Launch is refused while any error flag stands.
  assign blocked = protect_violation_flag_ff | access_error_flag_ff | fail_flag_ff;

  // Writing one to buffer-empty with a full sequence launches it.
  assign launch_now = wr_status & wdat[BIT_BUF_EMPTY] & (seq_ff == FPS_SEQ_CMD)
                      & ~blocked;

  // Writing zero after the word, before launch, aborts the sequence.
  assign abort_now = wr_status & ~wdat[BIT_BUF_EMPTY] & (seq_ff != FPS_SEQ_IDLE);

  // Out-of-order steps and an illegal code count as sequence faults.
  always_comb begin
    seq_fault = 1'b0;
    case (seq_ff)
      FPS_SEQ_IDLE: seq_fault = cmd_code_wr;
      FPS_SEQ_WORD: seq_fault = array_word_wr | (cmd_code_wr & cmd_code_illegal);
      FPS_SEQ_CMD:  seq_fault = array_word_wr | cmd_code_wr;
      default:      seq_fault = 1'b0;
    endcase
  end

  // Sequence tracker: word, then command, then launch.
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      FPS_SEQ_IDLE: begin
        if (array_word_wr) begin
          nxt_seq = FPS_SEQ_WORD;
        end
      end
      FPS_SEQ_WORD: begin
        if (seq_fault) begin
          nxt_seq = FPS_SEQ_IDLE;
        end else if (cmd_code_wr) begin
          nxt_seq = FPS_SEQ_CMD;
        end
      end
      FPS_SEQ_CMD: begin
        if (seq_fault) begin
          nxt_seq = FPS_SEQ_IDLE;
        end
      end
      default: nxt_seq = FPS_SEQ_IDLE;
    endcase
    // An abort or a launch always ends the sequence.
    if (abort_now | launch_now) begin
      nxt_seq = FPS_SEQ_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seq_ff <= FPS_SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // Buffer-empty clears on launch and sets when the engine takes the buffer.
  // A zero write leaves it alone; a one write without a sequence also leaves it set.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buffer_empty_flag_ff <= 1'b1;
    end else if (cmd_fetched) begin
      buffer_empty_flag_ff <= 1'b1;
    end else if (launch_now) begin
      buffer_empty_flag_ff <= 1'b0;
    end
  end

  // Complete drops with buffer-empty and rises only once nothing is queued or running.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      command_complete_flag_ff <= 1'b1;
    end else if (launch_now) begin
      command_complete_flag_ff <= 1'b0;
    end else if (buffer_empty_flag_ff & ~cmd_active & ~cmd_fetched) begin
      command_complete_flag_ff <= 1'b1;
    end
  end

  // Protection violation: a new event beats a clearing write.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      protect_violation_flag_ff <= 1'b0;
    end else if (prot_violation) begin
      protect_violation_flag_ff <= 1'b1;
    end else if (wr_status & wdat[BIT_PROT_VIOL]) begin
      protect_violation_flag_ff <= 1'b0;
    end
  end

  // Access error: sequence faults, aborts, and a stop during execution.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      access_error_flag_ff <= 1'b0;
    end else if (seq_fault | abort_now | (cpu_stop & ~command_complete_flag_ff)) begin
      access_error_flag_ff <= 1'b1;
    end else if (wr_status & wdat[BIT_ACC_ERR]) begin
      access_error_flag_ff <= 1'b0;
    end
  end

  // Erased result: set by a clean verify, cleared by the next valid launch.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      erased_flag_ff <= 1'b0;
    end else if (verify_done & verify_blank) begin
      erased_flag_ff <= 1'b1;
    end else if (launch_now) begin
      erased_flag_ff <= 1'b0;
    end
  end

  // Fail: set by a failed verify in special modes; cleared by one in special modes.
  // The host is expected to clear it before starting a special-mode sequence.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fail_flag_ff <= 1'b0;
    end else if (special_ff & verify_done & ~verify_blank) begin
      fail_flag_ff <= 1'b1;
    end else if (special_ff & wr_status & wdat[BIT_FAIL]) begin
      fail_flag_ff <= 1'b0;
    end
  end

  // One-cycle launch and abort strobes to the execution engine.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      launch_ff <= 1'b0;
      abort_ff  <= 1'b0;
    end else begin
      launch_ff <= launch_now;
      abort_ff  <= abort_now;
    end
  end
  assign cmd_launch = launch_ff;
  assign seq_abort  = abort_ff;

  // Interrupt requests follow flag and enable with one cycle of delay.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_empty_ff <= 1'b0;
      irq_done_ff  <= 1'b0;
    end else begin
      irq_empty_ff <= buffer_empty_flag_ff & flash_config_reg_ff[BIT_BUF_EMPTY_IE];
      irq_done_ff  <= command_complete_flag_ff & flash_config_reg_ff[BIT_COMPLETE_IE];
    end
  end
  assign irq_buffer_empty = irq_empty_ff;
  assign irq_complete     = irq_done_ff;

endmodule

// ### fps_flash_status_assertions.sv
// Purpose: Port-level checks of the flash protection and status block.
// Assumes: One clock domain; a bus write lands at the edge where ack is high.
// Notes:   Enables are mirrored here to judge the interrupt outputs.
`timescale 1ns/1ps
module fps_flash_status_chk
  import fps_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              prot_load,
  input wire logic              cmd_launch,
  input wire logic              seq_abort,
  input wire logic [7:0]        protection_config,
  input wire logic              irq_buffer_empty,
  input wire logic              irq_complete
);
  logic [1:0] ie_ff;  // Mirror of the two interrupt enables.
  logic       st_wr;  // A status write takes effect at this edge.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Scenario number from the open and two disable bits.
  function automatic logic [2:0] scn(input logic [7:0] v);
    return {v[7], v[5], v[2]};
  endfunction
  assign st_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
               & (wb_adr_i == STATUS_ADDR);
  // Follow config writes at the same edge the block applies them.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ie_ff <= 2'h0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == FLASH_CONFIG_ADDR) begin
      ie_ff <= wb_dat_i[7:6];
    end
  end
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow the request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_status_bit3: assert property (wb_ack_o && !wb_we_i && wb_adr_i == STATUS_ADDR |-> !wb_dat_o[3])
    else $error("unused status bit reads one");
  a_launch_cause: assert property (cmd_launch |-> $past(st_wr && wb_dat_i[7]))
    else $error("launch without a status write of one");
  a_abort_cause: assert property (seq_abort |-> $past(st_wr && !wb_dat_i[7]))
    else $error("abort without a status write of zero");
  a_prot_legal: assert property (!$stable(protection_config) && !$past(prot_load)
    |-> PROT_ALLOWED[scn($past(protection_config))][scn(protection_config)])
    else $error("illegal protection change");
  a_hi_size_lock: assert property (!$past(prot_load) && !$past(protection_config[5])
    |-> $stable(protection_config[4:3]))
    else $error("high size changed while range enabled");
  a_irq_be_gate: assert property (irq_buffer_empty |-> $past(ie_ff[1]))
    else $error("buffer interrupt without enable");
  a_irq_cc_gate: assert property (irq_complete |-> $past(ie_ff[0]))
    else $error("complete interrupt without enable");
  a_launch_irq: assert property (cmd_launch |=> !irq_buffer_empty && !irq_complete)
    else $error("interrupts stayed up after launch");
endmodule
bind fps_flash_status fps_flash_status_chk u_chk (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .prot_load, .cmd_launch,
  .seq_abort, .protection_config, .irq_buffer_empty, .irq_complete);

// ### fps_pkg.sv
// Purpose: Shared constants for the flash protection and status block.
// Assumes: Registers are byte wide and sit in the low lane of a 32-bit word.
// Notes:   Register indices are multiplied by four to form byte addresses.
package fps_pkg;

  // Address width of the register window, in byte address bits.
  localparam int unsigned ADDR_W = 6;

  // Register indices and their word-aligned byte addresses.
  localparam logic [3:0] FLASH_CONFIG_IDX   = 4'h3;
  localparam logic [3:0] PROTECT_CONFIG_IDX = 4'h4;
  localparam logic [3:0] STATUS_IDX         = 4'h5;
  localparam logic [ADDR_W-1:0] FLASH_CONFIG_ADDR   = {FLASH_CONFIG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PROTECT_CONFIG_ADDR = {PROTECT_CONFIG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR         = {STATUS_IDX, 2'b00};

  // Status register bit positions.
  localparam int unsigned BIT_BUF_EMPTY  = 7;
  localparam int unsigned BIT_COMPLETE   = 6;
  localparam int unsigned BIT_PROT_VIOL  = 5;
  localparam int unsigned BIT_ACC_ERR    = 4;
  localparam int unsigned BIT_ERASED     = 2;
  localparam int unsigned BIT_FAIL       = 1;
  localparam int unsigned BIT_DONE       = 0;

  // Flash configuration bit positions (interrupt enables).
  localparam int unsigned BIT_BUF_EMPTY_IE = 7;
  localparam int unsigned BIT_COMPLETE_IE  = 6;

  // Protection configuration field positions.
  localparam int unsigned BIT_PROT_OPEN = 7;
  localparam int unsigned BIT_HI_DIS    = 5;
  localparam int unsigned BIT_LO_DIS    = 2;
  localparam int unsigned HI_SIZE_LSB   = 3;
  localparam int unsigned LO_SIZE_LSB   = 0;

  // Values after reset.
  localparam logic [7:0] FLASH_CONFIG_RST   = 8'h00;
  localparam logic [7:0] PROTECT_CONFIG_RST = 8'hFF;

  // Allowed protection scenario changes: entry [from] has bit [to] set when legal.
  localparam logic [7:0] PROT_ALLOWED [8] = '{
    8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF
  };

  // Command write sequence states, one-hot.
  typedef enum logic [2:0] {
    FPS_SEQ_IDLE = 3'b001,
    FPS_SEQ_WORD = 3'b010,
    FPS_SEQ_CMD  = 3'b100
  } fps_seq_e;

endpackage

// ### fps_prot_filter.sv
// Purpose: Judges a write to the protection configuration against the current setting.
// Assumes: Purely combinational; the caller holds the register.
// Notes:   Size fields are merged first, then the scenario change is checked.
`timescale 1ns/1ps
module fps_prot_filter
  import fps_pkg::*;
(
  input  wire logic [7:0] cur_cfg,
  input  wire logic [7:0] wr_cfg,
  output logic      [7:0] merged_cfg,
  output logic            change_ok
);

  // Scenario number is formed from the open bit and the two range disables.
  function automatic logic [2:0] fps_scenario(input logic [7:0] cfg);
    fps_scenario = {cfg[BIT_PROT_OPEN], cfg[BIT_HI_DIS], cfg[BIT_LO_DIS]};
  endfunction

  // A size field only takes new data while its range is currently disabled.
  always_comb begin
    merged_cfg = wr_cfg;
    if (!cur_cfg[BIT_HI_DIS]) begin
      merged_cfg[HI_SIZE_LSB+1 -: 2] = cur_cfg[HI_SIZE_LSB+1 -: 2];
    end
    if (!cur_cfg[BIT_LO_DIS]) begin
      merged_cfg[LO_SIZE_LSB+1 -: 2] = cur_cfg[LO_SIZE_LSB+1 -: 2];
    end
  end

  // Look the requested change up in the transition table.
  assign change_ok = PROT_ALLOWED[fps_scenario(cur_cfg)][fps_scenario(wr_cfg)];

endmodule

// ### tb_top.sv
// Purpose: Register-level test of the flash protection and status block.
// Assumes: Classic single Wishbone cycles; engine model on the far side.
// Notes:   Bus waits and completion polls are bounded.
`timescale 1ns/1ps
module tb_top
  import fps_pkg::*;
;
  // Legal targets per current scenario, one bit per target.
  localparam logic [7:0] ALLOWED_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  logic              clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic              special_mode, prot_load, array_word_wr, cmd_code_wr, cmd_code_illegal;
  logic              cpu_stop, want_viol, want_blank, cmd_fetched, cmd_active, prot_violation;
  logic              verify_done, verify_blank, cmd_launch, seq_abort;
  logic              irq_buffer_empty, irq_complete;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o;
  logic [7:0]        prot_load_value, protection_config, rd_val, exp_v;
  int                n_mismatch, n_tests;
  fps_flash_status DUT (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .special_mode, .prot_load, .prot_load_value,
    .array_word_wr, .cmd_code_wr, .cmd_code_illegal, .cpu_stop, .cmd_fetched, .cmd_active,
    .prot_violation, .verify_done, .verify_blank, .cmd_launch, .seq_abort, .protection_config,
    .irq_buffer_empty, .irq_complete);
  fps_engine_model MODEL (.clk_sys, .reset_n, .cmd_launch, .want_viol, .want_blank,
    .cmd_fetched, .cmd_active, .prot_violation, .verify_done, .verify_blank);
  // Verdict and the single end of the run.
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One classic cycle; held until ack is sampled, then released for a cycle.
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    rd_val = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd_val, exp);
  endtask
  // Sequence steps from the decoders, one cycle each.
  task automatic word();
    array_word_wr <= 1'b1;
    @(posedge clk_sys);
    array_word_wr <= 1'b0;
  endtask
  task automatic cmd(input logic ill);
    cmd_code_wr      <= 1'b1;
    cmd_code_illegal <= ill;
    @(posedge clk_sys);
    cmd_code_wr <= 1'b0;
  endtask
  task automatic launch();
    word();
    cmd(1'b0);
    bus(1'b1, STATUS_ADDR, 8'h80);
  endtask
  // Poll until all commands are finished.
  task automatic wait_cc();
    int n;
    n = 0;
    do begin
      bus(1'b0, STATUS_ADDR, 8'h00);
      n++;
    end while (rd_val[BIT_COMPLETE] !== 1'b1 && n < 20);
    if (rd_val[BIT_COMPLETE] !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  function automatic logic [7:0] enc(input logic [2:0] s, input logic [1:0] h, input logic [1:0] l);
    return {s[2], 1'b0, s[1], h, s[0], l};
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, special_mode, prot_load, cpu_stop} = '0;
    {array_word_wr, cmd_code_wr, cmd_code_illegal, want_viol, want_blank} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, prot_load_value} = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc(STATUS_ADDR, 8'hC0);
    rdc(PROTECT_CONFIG_ADDR, 8'hFF);
    bus(1'b1, 6'h00, 8'hFF);
    rdc(6'h00, 8'h00);
    bus(1'b1, FLASH_CONFIG_ADDR, 8'hC0);
    @(posedge clk_sys);
    chk({6'h00, irq_buffer_empty, irq_complete}, 8'h03);
    // Every pair of scenarios, with size fields offered in each write.
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        prot_load_value <= enc(3'(f), 2'h0, 2'h0);
        prot_load <= 1'b1;
        @(posedge clk_sys);
        prot_load <= 1'b0;
        bus(1'b1, PROTECT_CONFIG_ADDR, enc(3'(t), 2'h3, 2'h3));
        exp_v = ALLOWED_TO[f][t] ? enc(3'(t), {2{f[1]}}, {2{f[0]}}) : enc(3'(f), 2'h0, 2'h0);
        rdc(PROTECT_CONFIG_ADDR, exp_v);
      end
    end
    launch();
    rdc(STATUS_ADDR, 8'h00);
    wait_cc();
    bus(1'b1, STATUS_ADDR, 8'h40);
    rdc(STATUS_ADDR, 8'hC0);
    word();
    bus(1'b1, STATUS_ADDR, 8'h00);
    rdc(STATUS_ADDR, 8'hD0);
    launch();
    rdc(STATUS_ADDR, 8'hD0);
    bus(1'b1, STATUS_ADDR, 8'h10);
    rdc(STATUS_ADDR, 8'hD0);
    bus(1'b1, STATUS_ADDR, 8'h10);
    bus(1'b1, STATUS_ADDR, 8'h00);
    rdc(STATUS_ADDR, 8'hC0);
    word();
    cmd(1'b1);
    rdc(STATUS_ADDR, 8'hD0);
    bus(1'b1, STATUS_ADDR, 8'h10);
    cpu_stop <= 1'b1;
    @(posedge clk_sys);
    cpu_stop <= 1'b0;
    rdc(STATUS_ADDR, 8'hC0);
    launch();
    cpu_stop <= 1'b1;
    @(posedge clk_sys);
    cpu_stop <= 1'b0;
    wait_cc();
    rdc(STATUS_ADDR, 8'hD0);
    bus(1'b1, STATUS_ADDR, 8'h10);
    want_viol <= 1'b1;
    launch();
    want_viol <= 1'b0;
    wait_cc();
    bus(1'b1, STATUS_ADDR, 8'h00);
    rdc(STATUS_ADDR, 8'hE0);
    bus(1'b1, STATUS_ADDR, 8'h20);
    rdc(STATUS_ADDR, 8'hC0);
    special_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    want_blank <= 1'b1;
    launch();
    rdc(STATUS_ADDR, 8'h00);
    wait_cc();
    rdc(STATUS_ADDR, 8'hC5);
    want_blank <= 1'b0;
    launch();
    wait_cc();
    rdc(STATUS_ADDR, 8'hC3);
    launch();
    rdc(STATUS_ADDR, 8'hC3);
    bus(1'b1, STATUS_ADDR, 8'h12);
    rdc(STATUS_ADDR, 8'hD1);
    bus(1'b1, STATUS_ADDR, 8'h10);
    rdc(STATUS_ADDR, 8'hC1);
    bus(1'b1, PROTECT_CONFIG_ADDR, 8'h00);
    rdc(PROTECT_CONFIG_ADDR, enc(3'h7, 2'h3, 2'h3));
    end_of_test();
  end
endmodule
